/* File: src/losd_params.svh */
// Constants for the LO synthesizer dividers and block standby control.
// Included by the package and by the core; holds definitions only.
`ifndef LOSD_PARAMS_SVH
`define LOSD_PARAMS_SVH

// Standby register reset value and bit positions
`define LOSD_BLOCK_STANDBY_BITS_RESET 8'hff
`define LOSD_BLOCK_STANDBY_BITS_USED 8'hfd
`define LOSD_BIT_ADC 0
`define LOSD_BIT_FRONTEND 2
`define LOSD_BIT_GAIN 3
`define LOSD_BIT_CLKSYN 4
`define LOSD_BIT_OSC 5
`define LOSD_BIT_LO 6
`define LOSD_BIT_REF 7

// Field widths
`define LOSD_BLOCK_STANDBY_BITS_W 8
`define LOSD_REF_W 14
`define LOSD_SWALLOW_W 3
`define LOSD_MAIN_W 13
`define LOSD_CODE_W 3
`define LOSD_LEVEL_W 4
`define LOSD_PRE_W 4

// Prescaler last counts: divide by eight and by nine
`define LOSD_PRE_LAST8 4'h7
`define LOSD_PRE_LAST9 4'h8

// Fast acquire limits in pump units above the base unit
`define LOSD_FA_FLOOR 3'h1
`define LOSD_BOOST_MAX 3'h7

`endif

/* File: src/losd_pkg.sv */
// Types shared by the LO synthesizer core and its bench.
// Assumes losd_params.svh is on the include path.
`include "losd_params.svh"
`default_nettype none

package losd_pkg;

    // Settings written over the serial configuration port
    typedef struct packed {
        logic [`LOSD_SWALLOW_W-1:0] lo_swallow_count;
        logic [`LOSD_MAIN_W-1:0] lo_main_count;
        logic [`LOSD_REF_W-1:0] lo_reference_divide;
        logic [`LOSD_CODE_W-1:0] lo_pump_current_code;
        logic lo_fast_acquire_enable;
        logic [`LOSD_REF_W-1:0] fast_acquire_divisor;
    } losd_cfg_t;

    // Charge pump command; level counts 0.625 mA units
    typedef struct packed {
        logic up;
        logic dn;
        logic oe;
        logic [`LOSD_LEVEL_W-1:0] level;
    } losd_pump_t;

    // Decoded power controls, each high while that block is off
    typedef struct packed {
        logic master_ref_off;
        logic ref_off;
        logic lo_off;
        logic osc_off;
        logic clksyn_off;
        logic gain_dac_off;
        logic frontend_off;
        logic adc_off;
        logic clkbuf_off;
    } losd_block_standby_bits_t;

    typedef enum logic [2:0] {
        LOSD_PFD_IDLE = 3'h1,
        LOSD_PFD_UP = 3'h2,
        LOSD_PFD_DN = 3'h4
    } losd_pfd_t;

endpackage

`default_nettype wire

/* File: src/losd_core.sv */
// LO synthesizer digital core: reference and feedback dividers,
// phase-frequency detector, pump current control, standby register.
// Assumes settings come from same-clock configuration logic;
// ref_in and vco_in are pins sampled at clk_in.
`include "losd_params.svh"
`default_nettype none

module losd_core (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ref_in,
    input wire logic vco_in,
    input wire logic block_standby_bits_wr_in,
    input wire logic [`LOSD_BLOCK_STANDBY_BITS_W-1:0] block_standby_bits_wdata_in,
    input wire losd_pkg::losd_cfg_t cfg_in,
    output logic [`LOSD_BLOCK_STANDBY_BITS_W-1:0] block_standby_bits_out,
    output losd_pkg::losd_block_standby_bits_t block_standby_bits_dec_out,
    output losd_pkg::losd_pump_t lo_pump_out,
    output logic ref_cmp_pulse_out,
    output logic fb_cmp_pulse_out
);
    import losd_pkg::*;

    function automatic logic [`LOSD_CODE_W-1:0] losd_max3(
        input logic [`LOSD_CODE_W-1:0] a,
        input logic [`LOSD_CODE_W-1:0] b,
        input logic [`LOSD_CODE_W-1:0] c
    );
        logic [`LOSD_CODE_W-1:0] m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    function automatic losd_block_standby_bits_t losd_decode(
        input logic [`LOSD_BLOCK_STANDBY_BITS_W-1:0] s
    );
        losd_block_standby_bits_t d;
        d.master_ref_off = ((s & `LOSD_BLOCK_STANDBY_BITS_USED) == `LOSD_BLOCK_STANDBY_BITS_USED);
        d.ref_off = s[`LOSD_BIT_REF];
        d.lo_off = s[`LOSD_BIT_LO];
        d.osc_off = s[`LOSD_BIT_OSC];
        d.clksyn_off = s[`LOSD_BIT_CLKSYN];
        d.gain_dac_off = s[`LOSD_BIT_GAIN];
        d.frontend_off = s[`LOSD_BIT_FRONTEND];
        d.adc_off = s[`LOSD_BIT_ADC];
        // Shared buffer stops only when both its users are off
        d.clkbuf_off = s[`LOSD_BIT_CLKSYN] & s[`LOSD_BIT_ADC];
        return d;
    endfunction

    // Pin synchronisers; edges are seen only on the second stage
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic [1:0] pin_last_q;
    logic ref_edge;
    logic vco_edge;

    assign ref_edge = pin_sync_q[0] & ~pin_last_q[0];
    assign vco_edge = pin_sync_q[1] & ~pin_last_q[1];

    // Standby register
    logic [`LOSD_BLOCK_STANDBY_BITS_W-1:0] block_standby_bits_q;
    logic [`LOSD_BLOCK_STANDBY_BITS_W-1:0] block_standby_bits_d;
    losd_block_standby_bits_t block_standby_bits_dec_q;
    logic lo_off;

    assign block_standby_bits_d = block_standby_bits_wr_in ? block_standby_bits_wdata_in : block_standby_bits_q;
    assign lo_off = block_standby_bits_q[`LOSD_BIT_LO];

    // Reference divider
    logic [`LOSD_REF_W-1:0] ref_cnt_q;
    logic [`LOSD_REF_W-1:0] ref_cnt_d;
    logic ref_tc;

    // A divide value of zero behaves as one
    // Gated by standby so no reference comparison pulse leaves a sleeping synthesizer
    assign ref_tc = ref_edge & ~lo_off & (ref_cnt_q <= `LOSD_REF_W'(1));
    assign ref_cnt_d = lo_off ? '0 :
                       ref_tc ? cfg_in.lo_reference_divide :
                       ref_edge ? ref_cnt_q - `LOSD_REF_W'(1) :
                       ref_cnt_q;

    // Dual-modulus feedback divider
    logic [`LOSD_PRE_W-1:0] pre_cnt_q;
    logic [`LOSD_PRE_W-1:0] pre_cnt_d;
    logic [`LOSD_PRE_W-1:0] pre_last;
    logic [`LOSD_SWALLOW_W-1:0] swl_cnt_q;
    logic [`LOSD_SWALLOW_W-1:0] swl_cnt_d;
    logic [`LOSD_MAIN_W-1:0] main_cnt_q;
    logic [`LOSD_MAIN_W-1:0] main_cnt_d;
    logic pre_wrap;
    logic fb_tc;

    // The sampled VCO must stay well under a quarter of clk_in
    assign pre_last = (swl_cnt_q != '0) ? `LOSD_PRE_LAST9 : `LOSD_PRE_LAST8;
    assign pre_wrap = vco_edge & (pre_cnt_q == pre_last);
    assign pre_cnt_d = lo_off ? '0 :
                       pre_wrap ? '0 :
                       vco_edge ? pre_cnt_q + `LOSD_PRE_W'(1) :
                       pre_cnt_q;
    assign fb_tc = pre_wrap & (main_cnt_q <= `LOSD_MAIN_W'(1));
    // N = 9*swallow + 8*(main - swallow) = 8*main + swallow
    assign main_cnt_d = lo_off ? '0 :
                        fb_tc ? cfg_in.lo_main_count :
                        pre_wrap ? main_cnt_q - `LOSD_MAIN_W'(1) :
                        main_cnt_q;
    assign swl_cnt_d = lo_off ? '0 :
                       fb_tc ? cfg_in.lo_swallow_count :
                       (pre_wrap && swl_cnt_q != '0) ?
                           swl_cnt_q - `LOSD_SWALLOW_W'(1) :
                       swl_cnt_q;

    // Phase-frequency detector
    losd_pfd_t pfd_q;
    losd_pfd_t pfd_d;

    always_comb begin
        pfd_d = pfd_q;
        case (pfd_q)
            LOSD_PFD_IDLE: begin
                // Coincident edges mean no phase error
                if (ref_tc && !fb_tc) begin
                    pfd_d = LOSD_PFD_UP;
                end else if (fb_tc && !ref_tc) begin
                    pfd_d = LOSD_PFD_DN;
                end
            end
            LOSD_PFD_UP: begin
                if (fb_tc) begin
                    pfd_d = LOSD_PFD_IDLE;
                end
            end
            LOSD_PFD_DN: begin
                if (ref_tc) begin
                    pfd_d = LOSD_PFD_IDLE;
                end
            end
            default: begin
                pfd_d = LOSD_PFD_IDLE;
            end
        endcase
        if (lo_off) begin
            pfd_d = LOSD_PFD_IDLE;
        end
    end

    // Fast acquire: count T intervals across each detector pulse
    logic fa_on;
    logic pfd_active;
    logic pulse_end;
    logic t_hit;
    logic [`LOSD_REF_W-1:0] t_cnt_q;
    logic [`LOSD_REF_W-1:0] t_cnt_d;
    logic [`LOSD_CODE_W-1:0] mult_q;
    logic [`LOSD_CODE_W-1:0] mult_d;
    logic [`LOSD_CODE_W-1:0] boost_q;
    logic [`LOSD_CODE_W-1:0] boost_d;
    logic [`LOSD_CODE_W-1:0] fa_max;

    assign fa_on = cfg_in.lo_fast_acquire_enable & ~lo_off;
    assign pfd_active = (pfd_q != LOSD_PFD_IDLE);
    assign pulse_end = pfd_active & (pfd_d == LOSD_PFD_IDLE);
    // T is the buffered reference divided by the divisor
    assign t_hit = ({1'b0, t_cnt_q} + {{`LOSD_REF_W{1'b0}}, 1'b1})
                   >= {1'b0, cfg_in.fast_acquire_divisor};
    assign t_cnt_d = !(fa_on && pfd_active) ? '0 :
                     !ref_edge ? t_cnt_q :
                     t_hit ? '0 :
                     t_cnt_q + `LOSD_REF_W'(1);
    assign mult_d = !(fa_on && pfd_active) ? '0 :
                    (ref_edge && t_hit && mult_q != `LOSD_BOOST_MAX) ?
                        mult_q + `LOSD_CODE_W'(1) :
                    mult_q;
    // The measured width takes effect on the next pulse
    assign boost_d = !fa_on ? '0 :
                     pulse_end ? mult_q :
                     boost_q;
    assign fa_max = losd_max3(`LOSD_FA_FLOOR, cfg_in.lo_pump_current_code,
                              boost_q);

    // Pump command, registered so every pin comes from a flop
    losd_pump_t pump_q;
    losd_pump_t pump_d;

    assign pump_d.up = ~lo_off & (pfd_d == LOSD_PFD_UP);
    assign pump_d.dn = ~lo_off & (pfd_d == LOSD_PFD_DN);
    assign pump_d.oe = ~lo_off;
    assign pump_d.level = fa_on ?
        {1'b0, fa_max} + `LOSD_LEVEL_W'(1) :
        {1'b0, cfg_in.lo_pump_current_code} + `LOSD_LEVEL_W'(1);

    always_ff @(posedge clk_in) begin
        pin_meta_q <= {vco_in, ref_in};
        pin_sync_q <= pin_meta_q;
        pin_last_q <= pin_sync_q;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            block_standby_bits_q <= `LOSD_BLOCK_STANDBY_BITS_RESET;
            block_standby_bits_dec_q <= losd_decode(`LOSD_BLOCK_STANDBY_BITS_RESET);
        end else begin
            block_standby_bits_q <= block_standby_bits_d;
            block_standby_bits_dec_q <= losd_decode(block_standby_bits_d);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ref_cnt_q <= '0;
            pre_cnt_q <= '0;
            main_cnt_q <= '0;
            swl_cnt_q <= '0;
        end else begin
            ref_cnt_q <= ref_cnt_d;
            pre_cnt_q <= pre_cnt_d;
            main_cnt_q <= main_cnt_d;
            swl_cnt_q <= swl_cnt_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pfd_q <= LOSD_PFD_IDLE;
            t_cnt_q <= '0;
            mult_q <= '0;
            boost_q <= '0;
            pump_q <= '0;
            ref_cmp_pulse_out <= 1'b0;
            fb_cmp_pulse_out <= 1'b0;
        end else begin
            pfd_q <= pfd_d;
            t_cnt_q <= t_cnt_d;
            mult_q <= mult_d;
            boost_q <= boost_d;
            pump_q <= pump_d;
            ref_cmp_pulse_out <= ref_tc;
            fb_cmp_pulse_out <= fb_tc;
        end
    end

    assign block_standby_bits_out = block_standby_bits_q;
    assign block_standby_bits_dec_out = block_standby_bits_dec_q;
    assign lo_pump_out = pump_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_ref_lead;
        ref_tc && !fb_tc && pfd_q == LOSD_PFD_IDLE && !lo_off;
    endsequence

    sequence s_fb_close;
        fb_tc && !lo_off;
    endsequence

    a_block_standby_bits_reset_ones: assert property (
        $past(!nrst_in) |-> block_standby_bits_q == `LOSD_BLOCK_STANDBY_BITS_RESET)
        else $error("standby register not all ones after reset");

    a_block_standby_bits_write_takes: assert property (
        block_standby_bits_wr_in |=> block_standby_bits_q == $past(block_standby_bits_wdata_in))
        else $error("standby write not stored");

    a_pfd_no_overlap: assert property (
        !(lo_pump_out.up && lo_pump_out.dn))
        else $error("up and down active together");

    a_up_on_lead: assert property (
        s_ref_lead |=> lo_pump_out.up ##0 pfd_q == LOSD_PFD_UP)
        else $error("up pulse missing after reference lead");

    a_up_ends_on_fb: assert property (
        pfd_q == LOSD_PFD_UP ##0 s_fb_close |=> !lo_pump_out.up)
        else $error("up pulse not cleared by feedback");

    a_lo_off_float: assert property (
        block_standby_bits_q[`LOSD_BIT_LO] [*2] |->
            !lo_pump_out.oe && !lo_pump_out.up && !lo_pump_out.dn)
        else $error("pump active while LO in standby");

    a_level_nominal: assert property (
        !cfg_in.lo_fast_acquire_enable && $stable(cfg_in) |=>
            lo_pump_out.level == {1'b0, $past(cfg_in.lo_pump_current_code)}
                + `LOSD_LEVEL_W'(1))
        else $error("pump level differs from code plus one");

    a_fa_floor: assert property (
        cfg_in.lo_fast_acquire_enable && !lo_off |=>
            lo_pump_out.level >= `LOSD_LEVEL_W'(2) || $past(lo_off))
        else $error("fast acquire level below two units");

    a_clkbuf_both: assert property (
        block_standby_bits_dec_out.clkbuf_off ==
            (block_standby_bits_q[`LOSD_BIT_CLKSYN] && block_standby_bits_q[`LOSD_BIT_ADC]))
        else $error("clock buffer control wrong");

    a_master_all_set: assert property (
        block_standby_bits_dec_out.master_ref_off ==
            ((block_standby_bits_q & `LOSD_BLOCK_STANDBY_BITS_USED) == `LOSD_BLOCK_STANDBY_BITS_USED))
        else $error("master reference control wrong");

    a_prescale_nine: assert property (
        pre_wrap && swl_cnt_q != '0 |-> pre_cnt_q == `LOSD_PRE_LAST9)
        else $error("prescaler not at nine while swallowing");

    a_ref_reload: assert property (
        ref_tc && !lo_off |=> ref_cnt_q == $past(cfg_in.lo_reference_divide)
            && ref_cmp_pulse_out)
        else $error("reference divider did not reload");

endmodule

`default_nettype wire

/* File: verification/losd_vco_model.sv */
// Behavioural loop filter plus VCO facing the LO pump output.
// Assumes the pump command is sampled on clk_in; output stays below clk/4.
`default_nettype none

module losd_vco_model (
    input wire logic clk_in,
    input wire losd_pkg::losd_pump_t pump_in,
    output logic vco_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import losd_pkg::*;

    // Half period in ns, clamped so the core can still count every edge
    int half_ns = 60;

    initial vco_out = 1'b0;

    always #(half_ns) vco_out = ~vco_out;

    // A floating pump leaves the filter voltage, and so the frequency, alone
    always @(posedge clk_in) begin
        if (pump_in.oe) begin
            if (pump_in.up && half_ns > 40) begin
                half_ns = half_ns - 1;
            end else if (pump_in.dn && half_ns < 200) begin
                half_ns = half_ns + 1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verification/lo_synth_dividers_standby_tb_top.sv */
// Self-checking bench for the LO synthesizer core.
// Assumes losd_pkg is compiled first and the VCO model closes the loop.
`default_nettype none

module lo_synth_dividers_standby_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import losd_pkg::*;

    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic ref_in = 1'b0;
    logic vco_in;
    logic block_standby_bits_wr_in = 1'b0;
    logic [7:0] block_standby_bits_wdata_in = 8'h00;
    losd_cfg_t cfg = '0;
    logic [7:0] rb;
    losd_block_standby_bits_t dec;
    losd_pump_t pump;
    logic ref_p;
    logic fb_p;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    int vcnt = 0;
    int n;
    logic fa_mon = 1'b0;
    logic [3:0] lo_min = 4'h2;
    logic [7:0] pats [10] = '{8'hfe, 8'hfb, 8'hf7, 8'hef, 8'hdf, 8'hbf, 8'h7f,
                              8'hfd, 8'h11, 8'h00};

    losd_core uut (
        .clk_in(clk_in), .nrst_in(nrst_in), .ref_in(ref_in), .vco_in(vco_in),
        .block_standby_bits_wr_in(block_standby_bits_wr_in), .block_standby_bits_wdata_in(block_standby_bits_wdata_in), .cfg_in(cfg),
        .block_standby_bits_out(rb), .block_standby_bits_dec_out(dec), .lo_pump_out(pump),
        .ref_cmp_pulse_out(ref_p), .fb_cmp_pulse_out(fb_p)
    );

    losd_vco_model vco (.clk_in(clk_in), .pump_in(pump), .vco_out(vco_in));

    always #5 clk_in = ~clk_in;

    // Reference pin toggles every four clocks: one period is eight clocks
    always @(negedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) begin
            ref_in <= ~ref_in;
        end
    end

    always @(posedge vco_in) vcnt = vcnt + 1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic [8:0] dec_exp(input logic [7:0] s);
        return {&(s | 8'h02), s[7], s[6], s[5], s[4], s[3], s[2], s[0], s[4] & s[0]};
    endfunction

    task automatic wr(input logic [7:0] d);
        @(negedge clk_in);
        block_standby_bits_wr_in = 1'b1;
        block_standby_bits_wdata_in = d;
        @(negedge clk_in);
        block_standby_bits_wr_in = 1'b0;
    endtask

    task automatic wait_pulse(input bit fb);
        int k;
        for (k = 0; k < 5000; k++) begin
            @(negedge clk_in);
            if (fb ? fb_p : ref_p) break;
        end
        if (k == 5000) check(16'h0, 16'h1);
    endtask

    // Reference gap in clocks, feedback gap in VCO edges
    task automatic gap(input bit fb, output int g);
        int a;
        wait_pulse(fb);
        wait_pulse(fb);
        a = fb ? vcnt : cyc;
        wait_pulse(fb);
        g = (fb ? vcnt : cyc) - a;
    endtask

    always @(negedge clk_in) begin
        if (nrst_in) begin
            check({15'h0, pump.up & pump.dn}, 16'h0);
            if (fa_mon && pump.oe) begin
                check({15'h0, pump.level >= lo_min && pump.level <= 4'h8}, 16'h1);
            end
        end
    end

    initial begin
        // Tests need under 5,000 clocks; allow 30,000
        #300_000;
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge clk_in);
        nrst_in = 1'b1;
        @(negedge clk_in);
        check({8'h0, rb}, 16'h00ff);
        check({7'h0, dec}, {7'h0, dec_exp(8'hff)});
        check({15'h0, pump.oe}, 16'h0);
        // Host duty: main count at least three and above swallow before LO wakes
        cfg.lo_reference_divide = 14'h0005;
        cfg.lo_main_count = 13'h0003;
        cfg.lo_swallow_count = 3'h2;
        cfg.fast_acquire_divisor = 14'h0001;
        foreach (pats[i]) begin
            wr(pats[i]);
            check({8'h0, rb}, {8'h0, pats[i]});
            check({7'h0, dec}, {7'h0, dec_exp(pats[i])});
        end
        wr(8'h10);
        check({15'h0, dec.clkbuf_off}, 16'h0);
        wr(8'h01);
        check({15'h0, dec.clkbuf_off}, 16'h0);
        wr(8'hbf);
        repeat (2) @(negedge clk_in);
        check({15'h0, pump.oe}, 16'h1);
        for (int c = 0; c < 8; c++) begin
            cfg.lo_pump_current_code = 3'(c);
            repeat (3) @(negedge clk_in);
            check({12'h0, pump.level}, 16'(c + 1));
        end
        gap(1'b0, n);
        check(16'(n), 16'd40);
        gap(1'b1, n);
        check(16'(n), 16'd26);
        gap(1'b1, n);
        check(16'(n), 16'd26);
        // Fast acquire never drops below the nominal code plus one
        cfg.lo_pump_current_code = 3'h0;
        cfg.lo_fast_acquire_enable = 1'b1;
        repeat (3) @(negedge clk_in);
        fa_mon = 1'b1;
        repeat (1500) @(negedge clk_in);
        // Pulses span many T intervals, so the boost saturates at seven units and the level at eight
        check({12'h0, pump.level}, 16'h8);
        fa_mon = 1'b0;
        lo_min = 4'h6;
        cfg.lo_pump_current_code = 3'h5;
        repeat (3) @(negedge clk_in);
        fa_mon = 1'b1;
        repeat (1500) @(negedge clk_in);
        fa_mon = 1'b0;
        wr(8'hff);
        repeat (2) @(negedge clk_in);
        check({13'h0, pump.oe, pump.up, pump.dn}, 16'h0);
        n = 0;
        repeat (200) begin
            @(negedge clk_in);
            n = n + int'(ref_p) + int'(fb_p);
        end
        check(16'(n), 16'h0);
        give_verdict();
    end
endmodule

`default_nettype wire
